// ### boot_switch_decoder.sv
`timescale 1ns/1ps
`default_nettype none
module boot_switch_decoder (
  // Clock and reset
  input  wire logic                     CORE_CLK,
  input  wire logic                     RST,
  // Switch banks, bit 0 is position 1
  input  wire logic [7:0]               BOOT_SELECT_BANK,
  input  wire logic [7:0]               BAUD_SELECT_BANK,
  input  wire logic [3:0]               ROTARY_CON,
  input  wire logic [3:0]               ROTARY_AUX,
  input  wire logic                     EXT_CLK_CON,
  input  wire logic                     EXT_CLK_AUX,
  // Decoded configuration
  output logic                          CFG_VALID,
  output boot_switch_pkg::boot_cfg_t    BOOT_CFG,
  output logic                          BOOT_ERROR,
  output logic                          ONLINE_DEBUG_MONITOR,
  output logic [3:0]                    SERIAL_LINE_UNIT_CON_SEL,
  output logic [3:0]                    SERIAL_LINE_UNIT_AUX_SEL,
  output logic [17:0]                   SERIAL_LINE_UNIT_CON_BAUDX2,
  output logic [17:0]                   SERIAL_LINE_UNIT_AUX_BAUDX2
);

  ////////////////////////////////////////////////////////////////////////////
  // Selector code to rate, in half-baud units so 134.5 stays exact
  // rate table
  function automatic logic [17:0] rate_x2(input logic [3:0] sel);
    logic [17:0] r;
    r = 18'h0;
    unique case (sel)
      4'h0: r = 18'd100;
      4'h1: r = 18'd150;
      4'h2: r = 18'd220;
      4'h3: r = 18'd269;
      4'h4: r = 18'd300;
      4'h5: r = 18'd600;
      4'h6: r = 18'd1200;
      4'h7: r = 18'd2400;
      4'h8: r = 18'd3600;
      4'h9: r = 18'd4000;
      4'ha: r = 18'd4800;
      4'hb: r = 18'd7200;
      4'hc: r = 18'd9600;
      4'hd: r = 18'd14400;
      4'he: r = 18'd19200;
      4'hf: r = 18'd38400;
    endcase
    return r;
  endfunction

  // Bank nibble to selector; only the one-hot 9600 setting is defined
  // bank decode
  function automatic logic [3:0] bank_sel(input logic [3:0] nib);
    return (nib == boot_switch_pkg::BANK_9600_CODE) ? boot_switch_pkg::SEL_9600
                                                    : boot_switch_pkg::SEL_DEFAULT;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Combinational decode of the boot bank
  boot_switch_pkg::boot_cfg_t cfg_nxt;
  logic [5:0] low6;
  assign low6 = BOOT_SELECT_BANK[5:0];

  always_comb begin
    cfg_nxt           = '0;
    cfg_nxt.mode      = boot_switch_pkg::BOOT_DEVICE;
    cfg_nxt.ctrl      = boot_switch_pkg::CTRL_NONE;
    cfg_nxt.ansi_term = BOOT_SELECT_BANK[boot_switch_pkg::POS_ANSI];
    cfg_nxt.mem_diag  = BOOT_SELECT_BANK[boot_switch_pkg::POS_MEM_DIAG];
    if (low6 == boot_switch_pkg::BOOT_INHIBIT) begin
      cfg_nxt.mode    = boot_switch_pkg::BOOT_NONE;
      cfg_nxt.inhibit = 1'b1;
    end else if (low6 == boot_switch_pkg::BOOT_LOOP) begin
      cfg_nxt.mode    = boot_switch_pkg::BOOT_SELFTEST;
    end else if (low6[5:3] == boot_switch_pkg::NET_ID) begin
      cfg_nxt.mode    = boot_switch_pkg::BOOT_NETWORK;
      cfg_nxt.unit    = low6[2:0];
      cfg_nxt.to_debug = (low6[2:0] > boot_switch_pkg::NET_LINK_MAX);
    end else if (low6[5:1] == 5'h01) begin
      // tape, one unit bit
      // Position 1 alone carries no type, so it falls through to the error branch
      cfg_nxt.ctrl    = boot_switch_pkg::CTRL_SERIAL_TAPE;
      cfg_nxt.unit    = {2'b00, low6[0]};
    end else if (low6[5:2] == 4'h1) begin
      cfg_nxt.ctrl    = low6[1] ? boot_switch_pkg::CTRL_FLOPPY_DD
                                : boot_switch_pkg::CTRL_FLOPPY_SD;
      cfg_nxt.unit    = {2'b00, low6[0]};
    end else if (low6[5:3] == 3'h1) begin
      cfg_nxt.ctrl    = boot_switch_pkg::CTRL_MASS_STORE;
      cfg_nxt.unit    = low6[2:0];
      cfg_nxt.auto_boot = (low6 == boot_switch_pkg::MSCP_AUTO);
    end else if (low6[5:2] == 4'h4) begin
      cfg_nxt.ctrl    = boot_switch_pkg::CTRL_CART_DISK;
      cfg_nxt.unit    = {1'b0, low6[1:0]};
    end else begin
      cfg_nxt.to_debug = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // One-shot capture; switches are static so a single sample suffices
  logic                       taken_r;
  boot_switch_pkg::boot_cfg_t cfg_r;
  logic [3:0]                 con_sel_r;
  logic [3:0]                 aux_sel_r;
  logic                       capture_now;

  // Checks other than a_hold key on this, not on taken_r alone: the release edge still applies reset
  assign capture_now = !RST && !taken_r;

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      taken_r <= 1'b0;
    end else begin
      taken_r <= 1'b1;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      cfg_r <= '0;
    end else if (!taken_r) begin
      cfg_r <= cfg_nxt;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      con_sel_r <= boot_switch_pkg::SEL_DEFAULT;
      aux_sel_r <= boot_switch_pkg::SEL_DEFAULT;
    end else if (!taken_r) begin
      con_sel_r <= EXT_CLK_CON ? ROTARY_CON
                 : bank_sel(BAUD_SELECT_BANK[boot_switch_pkg::BAUD_CON_LSB +: 4]);
      aux_sel_r <= EXT_CLK_AUX ? ROTARY_AUX
                 : bank_sel(BAUD_SELECT_BANK[boot_switch_pkg::BAUD_AUX_LSB +: 4]);
    end
  end

  assign CFG_VALID                   = taken_r;
  assign BOOT_CFG                    = cfg_r;
  assign BOOT_ERROR                  = cfg_r.to_debug;
  assign ONLINE_DEBUG_MONITOR        = cfg_r.to_debug;
  assign SERIAL_LINE_UNIT_CON_SEL    = con_sel_r;
  assign SERIAL_LINE_UNIT_AUX_SEL    = aux_sel_r;
  assign SERIAL_LINE_UNIT_CON_BAUDX2 = rate_x2(con_sel_r);
  assign SERIAL_LINE_UNIT_AUX_BAUDX2 = rate_x2(aux_sel_r);

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  sequence s_settled;
    taken_r ##1 taken_r;
  endsequence

  property p_hold;
    @(posedge CORE_CLK) disable iff (RST) s_settled |-> $stable(cfg_r);
  endproperty
  a_hold: assert property (p_hold) else $error("config changed after capture");

  property p_loop;
    @(posedge CORE_CLK) disable iff (RST)
      (capture_now && low6 == boot_switch_pkg::BOOT_LOOP) |=>
        (cfg_r.mode == boot_switch_pkg::BOOT_SELFTEST);
  endproperty
  a_loop: assert property (p_loop) else $error("selftest loop not decoded");

  property p_inhibit;
    @(posedge CORE_CLK) disable iff (RST)
      (capture_now && low6 == 6'h00) |=> cfg_r.inhibit;
  endproperty
  a_inhibit: assert property (p_inhibit) else $error("boot inhibit missed");

  property p_net;
    @(posedge CORE_CLK) disable iff (RST)
      (capture_now && low6[5:3] == 3'h7 && low6 != 6'h3f) |=>
        (cfg_r.mode == boot_switch_pkg::BOOT_NETWORK && cfg_r.unit == $past(low6[2:0]));
  endproperty
  a_net: assert property (p_net) else $error("network link wrong");

  property p_mscp;
    @(posedge CORE_CLK) disable iff (RST)
      (capture_now && low6[5:3] == 3'h1) |=>
        (cfg_r.unit == $past(low6[2:0]) && !cfg_r.to_debug);
  endproperty
  a_mscp: assert property (p_mscp) else $error("three-bit unit wrong");

  property p_undef;
    @(posedge CORE_CLK) disable iff (RST)
      (capture_now && low6[5:3] == 3'h3) |=> (BOOT_ERROR && ONLINE_DEBUG_MONITOR);
  endproperty
  a_undef: assert property (p_undef) else $error("undefined setting not flagged");

  property p_diag;
    @(posedge CORE_CLK) disable iff (RST)
      capture_now |=> (cfg_r.mem_diag == $past(BOOT_SELECT_BANK[6])
                    && cfg_r.ansi_term == $past(BOOT_SELECT_BANK[7]));
  endproperty
  a_diag: assert property (p_diag) else $error("terminal or diag bit wrong");

  property p_ext;
    @(posedge CORE_CLK) disable iff (RST)
      (capture_now && EXT_CLK_CON) |=> (con_sel_r == $past(ROTARY_CON));
  endproperty
  a_ext: assert property (p_ext) else $error("external selector not used");

  property p_bank;
    @(posedge CORE_CLK) disable iff (RST)
      (capture_now && !EXT_CLK_AUX && BAUD_SELECT_BANK[7:4] == 4'h1) |=>
        (SERIAL_LINE_UNIT_AUX_BAUDX2 == 18'd19200);
  endproperty
  a_bank: assert property (p_bank) else $error("bank 9600 not selected");

endmodule
`default_nettype wire

// ### boot_switch_decoder_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module boot_switch_decoder_tb_top;
  logic                       clk;
  logic                       rst;
  logic [7:0]                 bs;
  logic [7:0]                 bb;
  logic [3:0]                 rc;
  logic [3:0]                 ra;
  logic                       ec;
  logic                       ea;
  logic                       cv;
  logic                       be;
  logic                       odm;
  logic [3:0]                 cs;
  logic [3:0]                 as_sel;
  logic [17:0]                cb;
  logic [17:0]                ab;
  boot_switch_pkg::boot_cfg_t cfg;
  int                         mismatches;
  int                         checks_done;
  // Twice the rate, so the 134.5 entry stays whole
  localparam logic [17:0] BX2 [16] = '{18'h64, 18'h96, 18'hdc, 18'h10d, 18'h12c, 18'h258,
    18'h4b0, 18'h960, 18'he10, 18'hfa0, 18'h12c0, 18'h1c20, 18'h2580, 18'h3840, 18'h4b00,
    18'h9600};
  localparam logic [7:0] CORN [10] = '{8'hcf, 8'h00, 8'hbf, 8'h7f, 8'h3a, 8'h3b, 8'h01,
    8'h14, 8'h18, 8'h37};

  boot_switch_decoder dut (.CORE_CLK(clk), .RST(rst), .BOOT_SELECT_BANK(bs),
    .BAUD_SELECT_BANK(bb), .ROTARY_CON(rc), .ROTARY_AUX(ra), .EXT_CLK_CON(ec),
    .EXT_CLK_AUX(ea), .CFG_VALID(cv), .BOOT_CFG(cfg), .BOOT_ERROR(be),
    .ONLINE_DEBUG_MONITOR(odm), .SERIAL_LINE_UNIT_CON_SEL(cs),
    .SERIAL_LINE_UNIT_AUX_SEL(as_sel), .SERIAL_LINE_UNIT_CON_BAUDX2(cb),
    .SERIAL_LINE_UNIT_AUX_BAUDX2(ab));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic chk(input logic ok, input string msg);
    checks_done++;
    if (!ok) begin
      mismatches++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Expected fields and a care mask; unit and type are left out where undefined
  function automatic void exp_f(input logic [7:0] b, output boot_switch_pkg::boot_cfg_t e,
                                output boot_switch_pkg::boot_cfg_t m);
    logic [5:0] l;
    l = b[5:0];
    e = '0;
    m = '1;
    e.ansi_term = b[7];
    e.mem_diag = b[6];
    if (l == boot_switch_pkg::BOOT_INHIBIT) begin
      e.mode = boot_switch_pkg::BOOT_NONE;
      e.inhibit = 1'b1;
      m.ctrl = '0;
      m.unit = '0;
    end else if (l == boot_switch_pkg::BOOT_LOOP) begin
      e.mode = boot_switch_pkg::BOOT_SELFTEST;
      m.ctrl = '0;
      m.unit = '0;
    end else if (l[5:3] == boot_switch_pkg::NET_ID && l[2:0] <= boot_switch_pkg::NET_LINK_MAX) begin
      e.mode = boot_switch_pkg::BOOT_NETWORK;
      e.unit = l[2:0];
      m.ctrl = '0;
    end else if (l[5:1] == 5'h01) begin
      e.ctrl = boot_switch_pkg::CTRL_SERIAL_TAPE;
      e.unit = {2'h0, l[0]};
    end else if (l[5:2] == 4'h1) begin
      e.ctrl = l[1] ? boot_switch_pkg::CTRL_FLOPPY_DD : boot_switch_pkg::CTRL_FLOPPY_SD;
      e.unit = {2'h0, l[0]};
    end else if (l[5:3] == 3'h1) begin
      e.ctrl = boot_switch_pkg::CTRL_MASS_STORE;
      e.unit = l[2:0];
      e.auto_boot = (l == boot_switch_pkg::MSCP_AUTO);
    end else if (l[5:2] == 4'h4) begin
      e.ctrl = boot_switch_pkg::CTRL_CART_DISK;
      e.unit = {1'h0, l[1:0]};
    end else begin
      e.to_debug = 1'b1;
      m.mode = boot_switch_pkg::boot_mode_t'(2'h0);
      m.ctrl = '0;
      m.unit = '0;
    end
  endfunction

  // Reset, capture one setting, then scramble every switch except ra and ea and look again
  task automatic run(input logic [7:0] b);
    boot_switch_pkg::boot_cfg_t e;
    boot_switch_pkg::boot_cfg_t m;
    logic [3:0]                 ce;
    logic [3:0]                 ae;
    @(posedge clk);
    rst <= 1'b1;
    bs <= b;
    bb <= 8'($urandom);
    rc <= 4'($urandom);
    ra <= 4'($urandom);
    ec <= 1'($urandom);
    ea <= 1'($urandom);
    @(posedge clk);
    @(negedge clk);
    chk(cv === 1'b0, "valid during reset");
    @(posedge clk);
    rst <= 1'b0;
    exp_f(bs, e, m);
    ce = ec ? rc : boot_switch_pkg::SEL_9600;
    ae = ea ? ra : boot_switch_pkg::SEL_9600;
    repeat (2) @(posedge clk);
    repeat (2) begin
      @(negedge clk);
      chk(cv === 1'b1, "not valid");
      chk((cfg & m) === (e & m), "boot fields");
      chk(be === e.to_debug && odm === e.to_debug, "error flag");
      chk(cs === ce && as_sel === ae, "rate select");
      chk(cb === BX2[ce] && ab === BX2[ae], "rate value");
      @(posedge clk);
      bs <= 8'($urandom);
      bb <= 8'($urandom);
      rc <= 4'($urandom);
      ec <= 1'($urandom);
      repeat (2) @(posedge clk);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    rst = 1'b1;
    bs = '0;
    bb = '0;
    rc = '0;
    ra = '0;
    ec = 1'b0;
    ea = 1'b0;
    mismatches = 0;
    checks_done = 0;
    void'($urandom(32'h719f));
    repeat (3) @(posedge clk);
    for (int i = 0; i < 10; i++) begin
      run(CORN[i]);
    end
    $display("test corners done");
    // Every boot code once, with random terminal and memory bits
    for (int i = 0; i < 64; i++) begin
      run({2'($urandom), 6'(i)});
    end
    $display("test sweep done");
    end_of_test();
  end

  // About eleven cycles a case, so this is far beyond a healthy run
  initial begin
    #400000;
    mismatches++;
    end_of_test();
  end
endmodule
`default_nettype wire

// ### boot_switch_pkg.sv
`default_nettype none
package boot_switch_pkg;

  // Boot selection bank decode
  localparam logic [3:0] CTRL_SERIAL_TAPE = 4'h0;
  localparam logic [3:0] CTRL_FLOPPY_SD   = 4'h1;
  localparam logic [3:0] CTRL_FLOPPY_DD   = 4'h2;
  localparam logic [3:0] CTRL_MASS_STORE  = 4'h3;
  localparam logic [3:0] CTRL_CART_DISK   = 4'h4;
  localparam logic [3:0] CTRL_NONE        = 4'hf;
  localparam logic [5:0] BOOT_INHIBIT     = 6'h00;
  localparam logic [5:0] BOOT_LOOP        = 6'h3f;
  localparam logic [5:0] MSCP_AUTO        = 6'h0f;
  localparam logic [2:0] NET_ID           = 3'h7;
  localparam logic [2:0] NET_LINK_MAX     = 3'h2;
  localparam int         POS_MEM_DIAG     = 6;
  localparam int         POS_ANSI         = 7;

  // Baud bank: console in low nibble, second unit in high nibble
  localparam int         BAUD_CON_LSB     = 0;
  localparam int         BAUD_AUX_LSB     = 4;
  localparam logic [3:0] BANK_9600_CODE   = 4'h1;
  localparam logic [3:0] SEL_9600         = 4'he;
  localparam logic [3:0] SEL_DEFAULT      = 4'he;

  typedef enum logic [1:0] {
    BOOT_DEVICE  = 2'b00,
    BOOT_NETWORK = 2'b01,
    BOOT_SELFTEST= 2'b10,
    BOOT_NONE    = 2'b11
  } boot_mode_t;

  typedef struct packed {
    boot_mode_t mode;
    logic [3:0] ctrl;
    logic [2:0] unit;
    logic       auto_boot;
    logic       mem_diag;
    logic       ansi_term;
    logic       inhibit;
    logic       to_debug;
  } boot_cfg_t;

endpackage
`default_nettype wire
